//--- rtl/hsm_defines.vh
// hsm_defines.vh: constants shared by the handshake serial master.
// assumes it is included by bare name from the rtl files; definitions only.
`ifndef HSM_DEFINES_VH
`define HSM_DEFINES_VH

// system clock and serial rate
`define HSM_CLK_HZ 50000000
`define HSM_BIT_RATE 1000000
`define HSM_MIN_BIT_RATE 200000
`define HSM_SCK_HALF (`HSM_CLK_HZ / (2 * `HSM_BIT_RATE))

// time base: system clock divided by 256, about 195 kHz at 50 MHz, though the tick counts below assume 125 kHz
`define HSM_PRESCALE 256
`define HSM_BASE_KHZ 125

// slot period and handshake timeout, in their own units
`define HSM_SLOT_US 1000
`define HSM_TIMEOUT_US 16
// slot is a least time (round up), timeout a longest time (round down)
`define HSM_SLOT_TICKS ((`HSM_SLOT_US * `HSM_BASE_KHZ + 999) / 1000)
`define HSM_TIMEOUT_TICKS ((`HSM_TIMEOUT_US * `HSM_BASE_KHZ) / 1000)

// character format and slot limits
`define HSM_CHAR_BITS 8
`define HSM_MAX_CHARS 63
`define HSM_DEF_CHARS 8

// data transfer kinds; full duplex is the default encoding
`define HSM_MODE_TXRX 2'b00
`define HSM_MODE_TX 2'b01
`define HSM_MODE_RX 2'b10

// status reply layout: kind in bits 7:6, count in bits 5:0
`define HSM_REPLY_CAN_SEND 2'b01
`define HSM_REPLY_CAN_TAKE 2'b00
`define HSM_IDLE_FILL 8'h00

`endif

//--- rtl/hsm_buffer.v
// hsm_buffer.v: simple dual-port character memory, registered read data.
// assumes one clock; write and read ports are independent.
`timescale 1ns/100ps
`default_nettype none

module hsm_buffer #(
    parameter WIDTH = 8,
    parameter DEPTH = 64,
    parameter AW = 6
) (
    input wire clock,
    input wire resetn,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [WIDTH-1:0] wr_data,
    input wire [AW-1:0] rd_addr,
    output reg [WIDTH-1:0] rd_data
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];

    // write port, no reset on the array
    always @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // read port, data one cycle after the address
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rd_data <= {WIDTH{1'b0}};
        end else begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule

`default_nettype wire

//--- rtl/hsm_master.v
// hsm_master.v: serial master with busy handshake, two slaves, 640 us slots.
// assumes busy_in and serial_data_in are synchronous to clock.
`timescale 1ns/100ps
`default_nettype none
`include "hsm_defines.vh"

module hsm_master #(
    parameter [7:0] CMD_STATUS = 8'h01, // arbitrary command codes
    parameter [7:0] CMD_RECEIVE = 8'h02,
    parameter [7:0] CMD_SEND = 8'h03,
    parameter [7:0] CMD_SEND_RECEIVE = 8'h04,
    parameter AW = 6
) (
    input wire clock,
    input wire resetn,
    input wire handshake_en,
    input wire [1:0] xfer_mode,
    input wire [AW-1:0] req_count,
    input wire busy_in,
    input wire serial_data_in,
    output reg serial_clock_out,
    output reg serial_data_out,
    output reg slave_select_one_n,
    output reg slave_select_two_n,
    input wire tx_wr_en,
    input wire [AW-1:0] tx_wr_addr,
    input wire [7:0] tx_wr_data,
    input wire [AW-1:0] rx_rd_addr,
    output wire [7:0] rx_rd_data,
    output reg transfer_done_event,
    output reg slot_tick_event,
    output reg timeout_tick_event,
    output reg count_short_event,
    output reg [7:0] status_reply,
    output reg data_slot,
    output reg active_slave
);

    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_HWAIT = 5'h02;
    localparam [4:0] ST_SHIFT = 5'h04;
    localparam [4:0] ST_NEXT = 5'h08;
    localparam [4:0] ST_END = 5'h10;

    // counter end points worked out as integers, then cut to each counter's width
    localparam integer PRE_LAST_I = `HSM_PRESCALE - 1;
    localparam integer SLOT_LAST_I = `HSM_SLOT_TICKS - 1;
    localparam integer TO_LAST_I = `HSM_TIMEOUT_TICKS - 1;
    localparam integer HALF_LAST_I = `HSM_SCK_HALF - 1;
    localparam integer EDGE_LAST_I = 2 * `HSM_CHAR_BITS - 1;
    localparam [7:0] PRE_LAST = PRE_LAST_I[7:0];
    localparam [6:0] SLOT_LAST = SLOT_LAST_I[6:0];
    localparam [3:0] TO_LAST = TO_LAST_I[3:0];
    localparam [5:0] HALF_LAST = HALF_LAST_I[5:0];
    localparam [4:0] EDGE_LAST = EDGE_LAST_I[4:0];

    // command byte for the data slot of the chosen kind
    function [7:0] data_cmd;
        input [1:0] mode;
        begin
            case (mode)
                `HSM_MODE_TX: data_cmd = CMD_SEND;
                `HSM_MODE_RX: data_cmd = CMD_RECEIVE;
                default: data_cmd = CMD_SEND_RECEIVE;
            endcase
        end
    endfunction

    reg [4:0] state_r;
    reg [7:0] pre_r;
    reg [6:0] slot_r;
    reg [3:0] to_r;
    reg [5:0] half_r;
    reg [4:0] edge_r;
    reg [7:0] shift_r;
    reg cmd_done_r;
    reg [AW-1:0] idx_r;
    reg [AW-1:0] target_r;
    reg ok_r;
    wire base_tick;
    wire slot_tick;
    wire [7:0] tx_rd_data;
    wire [AW-1:0] tx_rd_addr;
    wire [AW-1:0] idx_inc;
    wire rx_we;
    wire [1:0] reply_kind;
    wire [AW-1:0] reply_count;
    wire kind_ok;

    // the prescaler runs free from reset, so slot ticks keep a fixed rhythm
    // about 195 kHz time base and 640 us slot tick from it
    assign base_tick = (pre_r == PRE_LAST);
    assign slot_tick = base_tick && (slot_r == SLOT_LAST);

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pre_r <= 8'h00;
            slot_r <= 7'h00;
            slot_tick_event <= 1'b0;
        end else begin
            pre_r <= pre_r + 8'h01;
            slot_tick_event <= slot_tick;
            if (base_tick) begin
                slot_r <= slot_tick ? 7'h00 : slot_r + 7'h01;
            end
        end
    end

    // reply decode: kind in the top two bits, count in the six low bits
    // a reply with its top bit set is treated as no reply at all
    assign reply_kind = shift_r[7:6];
    assign reply_count = shift_r[5:0];
    assign kind_ok = (xfer_mode == `HSM_MODE_RX) ? (reply_kind == `HSM_REPLY_CAN_SEND) :
                     (xfer_mode == `HSM_MODE_TX) ? (reply_kind == `HSM_REPLY_CAN_TAKE) :
                     (reply_kind[1] == 1'b0);

    // look one character ahead so the byte is ready on entering the wait
    // the memory answers a cycle after its address, hence idx_inc in ST_NEXT
    assign idx_inc = idx_r + {{(AW-1){1'b0}}, 1'b1};
    assign tx_rd_addr = (state_r == ST_NEXT && cmd_done_r) ? idx_inc : idx_r;
    assign rx_we = (state_r == ST_NEXT) && cmd_done_r && data_slot &&
                   (xfer_mode != `HSM_MODE_TX);

    // sequence and shifter
    // a slot tick that arrives mid-sequence is not seen, that slot is lost
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
            to_r <= 4'h0;
            half_r <= 6'h00;
            edge_r <= 5'h00;
            shift_r <= 8'h00;
            cmd_done_r <= 1'b0;
            idx_r <= {AW{1'b0}};
            target_r <= {AW{1'b0}};
            ok_r <= 1'b0;
            serial_clock_out <= 1'b1;
            serial_data_out <= 1'b1;
            slave_select_one_n <= 1'b1;
            slave_select_two_n <= 1'b1;
            transfer_done_event <= 1'b0;
            timeout_tick_event <= 1'b0;
            count_short_event <= 1'b0;
            status_reply <= 8'h00;
            data_slot <= 1'b0;
            active_slave <= 1'b0;
        end else begin
            // event outputs are single-cycle pulses
            transfer_done_event <= 1'b0;
            timeout_tick_event <= 1'b0;
            count_short_event <= 1'b0;
            case (state_r)
                // wait for the slot tick, then select the current slave
                ST_IDLE: begin
                    if (slot_tick) begin
                        slave_select_one_n <= active_slave;
                        slave_select_two_n <= ~active_slave;
                        to_r <= 4'h0;
                        cmd_done_r <= 1'b0;
                        idx_r <= {AW{1'b0}};
                        target_r <= data_slot ? req_count : {{(AW-1){1'b0}}, 1'b1};
                        state_r <= ST_HWAIT;
                    end
                end
                // handshake wait with timeout on the time base
                // the base runs free, so the timeout falls between 5.12 and 10.24 us
                ST_HWAIT: begin
                    if (!handshake_en || !busy_in) begin
                        if (!cmd_done_r) begin
                            shift_r <= data_slot ? data_cmd(xfer_mode) : CMD_STATUS;
                        end else if (!data_slot || xfer_mode == `HSM_MODE_RX) begin
                            shift_r <= `HSM_IDLE_FILL;
                        end else begin
                            shift_r <= tx_rd_data;
                        end
                        half_r <= 6'h00;
                        edge_r <= 5'h00;
                        state_r <= ST_SHIFT;
                    end else if (base_tick) begin
                        if (to_r == TO_LAST) begin
                            timeout_tick_event <= 1'b1;
                            ok_r <= 1'b0;
                            state_r <= ST_END;
                        end else begin
                            to_r <= to_r + 4'h1;
                        end
                    end
                end
                // one character, type 1: idle high, drive on fall, sample on rise
                ST_SHIFT: begin
                    if (half_r == HALF_LAST) begin
                        half_r <= 6'h00;
                        serial_clock_out <= ~serial_clock_out;
                        if (serial_clock_out) begin
                            serial_data_out <= shift_r[7];
                        end else begin
                            shift_r <= {shift_r[6:0], serial_data_in};
                        end
                        if (edge_r == EDGE_LAST) begin
                            transfer_done_event <= 1'b1;
                            state_r <= ST_NEXT;
                        end else begin
                            edge_r <= edge_r + 5'h01;
                        end
                    end else begin
                        half_r <= half_r + 6'h01;
                    end
                end
                // account for the character just moved, then wait again or end
                ST_NEXT: begin
                    to_r <= 4'h0;
                    if (!cmd_done_r) begin
                        cmd_done_r <= 1'b1;
                        state_r <= (target_r == {AW{1'b0}}) ? ST_END : ST_HWAIT;
                        ok_r <= 1'b0;
                    end else begin
                        idx_r <= idx_inc;
                        if (!data_slot) begin
                            status_reply <= shift_r;
                            ok_r <= kind_ok && (reply_count >= req_count);
                            count_short_event <= kind_ok && (reply_count < req_count);
                        end
                        state_r <= (idx_inc >= target_r) ? ST_END : ST_HWAIT;
                    end
                end
                // deselect; keep slave for its data slot, else switch slave
                // a timed-out or refused status slot never gets a data slot
                ST_END: begin
                    slave_select_one_n <= 1'b1;
                    slave_select_two_n <= 1'b1;
                    if (!data_slot && ok_r) begin
                        data_slot <= 1'b1;
                    end else begin
                        data_slot <= 1'b0;
                        active_slave <= ~active_slave;
                    end
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // transmit characters written by the user, read out per character
    hsm_buffer #(
        .WIDTH(8),
        .DEPTH(1 << AW),
        .AW(AW)
    ) u_tx_buf (
        .clock(clock),
        .resetn(resetn),
        .wr_en(tx_wr_en),
        .wr_addr(tx_wr_addr),
        .wr_data(tx_wr_data),
        .rd_addr(tx_rd_addr),
        .rd_data(tx_rd_data)
    );

    // received characters of the last data slot
    hsm_buffer #(
        .WIDTH(8),
        .DEPTH(1 << AW),
        .AW(AW)
    ) u_rx_buf (
        .clock(clock),
        .resetn(resetn),
        .wr_en(rx_we),
        .wr_addr(idx_r),
        .wr_data(shift_r),
        .rd_addr(rx_rd_addr),
        .rd_data(rx_rd_data)
    );

endmodule

`default_nettype wire

//--- sim/hsm_checker.sv
// hsm_checker.sv: port-level assertions for the handshake serial master.
// assumes it is bound to hsm_master; one clock, reset active low.
`timescale 1ns/100ps
`default_nettype none
module hsm_checker (
    input wire logic clock,
    input wire logic resetn,
    input wire logic handshake_en,
    input wire logic busy_in,
    input wire logic serial_clock_out,
    input wire logic serial_data_out,
    input wire logic slave_select_one_n,
    input wire logic slave_select_two_n,
    input wire logic transfer_done_event,
    input wire logic slot_tick_event,
    input wire logic timeout_tick_event,
    input wire logic data_slot,
    input wire logic active_slave
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    logic [5:0] wait_r;
    logic [15:0] gap_r;
    logic seen_r;
    wire idle_n = slave_select_one_n & slave_select_two_n;
    // run of busy-high cycles with the clock idle, and spacing of slot ticks
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wait_r <= 6'h00;
            gap_r <= 16'h0000;
            seen_r <= 1'b0;
        end else begin
            wait_r <= (handshake_en && busy_in && serial_clock_out) ?
                ((wait_r == 6'h3f) ? wait_r : wait_r + 6'h01) : 6'h00;
            gap_r <= slot_tick_event ? 16'h0000 : gap_r + 16'h0001;
            seen_r <= seen_r | slot_tick_event;
        end
    end
    a_select_first: assert property (
        $fell(serial_clock_out) |-> !idle_n) else $error("clock moved with no slave selected");
    a_sel_one_match: assert property (
        !slave_select_one_n |-> !active_slave && slave_select_two_n)
        else $error("select one low for wrong slave");
    a_sel_two_match: assert property (
        !slave_select_two_n |-> active_slave) else $error("select two low for wrong slave");
    a_busy_gate: assert property (
        wait_r >= 6'd30 |=> serial_clock_out) else $error("clocking began while busy high");
    a_clock_idle: assert property (
        idle_n |-> serial_clock_out) else $error("serial clock low while idle");
    a_data_stable: assert property (
        !idle_n && $past(!idle_n) && !$fell(serial_clock_out) |-> $stable(serial_data_out))
        else $error("data out changed off a falling clock");
    a_done_shape: assert property (
        transfer_done_event |-> (serial_clock_out && !$past(serial_clock_out)
        && !$past(serial_clock_out, 2)) ##1 !transfer_done_event)
        else $error("done pulse misplaced");
    a_timeout_exit: assert property (
        timeout_tick_event |-> ##[1:3] idle_n) else $error("no deselect after timeout");
    a_timeout_cause: assert property (
        timeout_tick_event |-> handshake_en && $past(busy_in))
        else $error("timeout without busy handshake");
    a_slot_period: assert property (
        slot_tick_event && seen_r |-> gap_r == 16'd31999) else $error("slot period wrong");
    c_done: cover property (transfer_done_event);
    c_timeout: cover property (timeout_tick_event);
    c_data_slot: cover property ($rose(data_slot));
endmodule
`default_nettype wire

//--- sim/hsm_slave_model.sv
// hsm_slave_model.sv: behavioural slave with busy handshake and type 1 phase.
// assumes sel_n is low while either select is low; runs on the master clock.
`timescale 1ns/100ps
`default_nettype none
module hsm_slave_model (
    input wire logic clock,
    input wire logic sel_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic mute,
    input wire logic [7:0] lag,
    output logic busy,
    output logic miso
);
    logic [7:0] ob [0:7];
    logic [7:0] got [0:7];
    logic [7:0] sh;
    logic psck, psel;
    int ng, nb, wt;
    initial begin
        busy = 1'b1;
        miso = 1'b0;
        psck = 1'b1;
        psel = 1'b1;
        sh = 8'h00;
        ng = 0;
        nb = 0;
        wt = 0;
    end
    // busy rises on a character's last rising edge, falls lag cycles later; shift on sck edges
    always @(posedge clock) begin
        psck <= sck;
        psel <= sel_n;
        busy <= sel_n || mute || (wt < lag) || (!psck && sck && nb == 7);
        if (sel_n) begin
            miso <= ~miso; // released line does not hold its level
            wt <= 0;
        end else begin
            wt <= wt + 1;
            if (psel) begin
                ng <= 0;
                nb <= 0;
            end
            if (psck && !sck)
                miso <= ob[ng][7 - nb];
            if (!psck && sck) begin
                sh <= {sh[6:0], mosi};
                nb <= (nb == 7) ? 0 : nb + 1;
                if (nb == 7) begin
                    got[ng] <= {sh[6:0], mosi};
                    ng <= ng + 1;
                    wt <= 0;
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- sim/tb_handshake_spi_master.sv
// tb_handshake_spi_master.sv: status slot without handshake, duplex data slot, timeout slot.
// assumes the master, its memory, the checker and the slave model compile first.
`timescale 1ns/100ps
`default_nettype none
module tb_handshake_spi_master;
    logic clock, resetn, handshake_en, tx_wr_en, mute;
    logic busy, sdi, sck, sdo, s1_n, s2_n, tde, ste, tte, cse, dslot, act;
    logic [1:0] xfer_mode;
    logic [5:0] req_count, tx_wr_addr, rx_rd_addr;
    logic [7:0] tx_wr_data, rx_rd_data, status_reply, lag, d;
    logic [7:0] exp_tx [$];
    logic [7:0] exp_rx [$];
    int err_count, total_checks;
    int n_done = 0;
    int n_short = 0;
    int n_tick = 0;
    localparam logic [7:0] CMD_STAT = 8'h3c; // arbitrary command codes for this bench
    localparam logic [7:0] CMD_DUPLEX = 8'hc3;
    // count the done, short-count and slot tick pulses the design raises over the whole run
    always @(posedge clock) begin
        if (tde === 1'b1)
            n_done <= n_done + 1;
        if (cse === 1'b1)
            n_short <= n_short + 1;
        if (ste === 1'b1)
            n_tick <= n_tick + 1;
    end
    hsm_master #(.CMD_STATUS(CMD_STAT), .CMD_SEND_RECEIVE(CMD_DUPLEX)) hsm_master_inst (
        .clock(clock), .resetn(resetn), .handshake_en(handshake_en),
        .xfer_mode(xfer_mode), .req_count(req_count), .busy_in(busy), .serial_data_in(sdi),
        .serial_clock_out(sck), .serial_data_out(sdo), .slave_select_one_n(s1_n),
        .slave_select_two_n(s2_n), .tx_wr_en(tx_wr_en), .tx_wr_addr(tx_wr_addr),
        .tx_wr_data(tx_wr_data), .rx_rd_addr(rx_rd_addr), .rx_rd_data(rx_rd_data),
        .transfer_done_event(tde), .slot_tick_event(ste), .timeout_tick_event(tte),
        .count_short_event(cse), .status_reply(status_reply), .data_slot(dslot),
        .active_slave(act));
    hsm_slave_model hsm_slave_model_inst (.clock(clock), .sel_n(s1_n & s2_n), .sck(sck),
        .mosi(sdo), .mute(mute), .lag(lag), .busy(busy), .miso(sdi));
    // compare one value and report a mismatch
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // verdict and end of run
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // wait for a slot tick and the end of the sequence it starts
    task automatic run_slot;
        @(posedge clock iff ste);
        @(posedge clock iff !(s1_n && s2_n));
        @(posedge clock iff (s1_n && s2_n));
        repeat (3) @(posedge clock);
    endtask
    // 50 MHz clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // watchdog: three slots plus margin
    initial begin
        #(100000 * 20);
        err_count++;
        finish_test();
    end
    // main sequence
    initial begin
        void'($urandom(65));
        err_count = 0;
        total_checks = 0;
        resetn = 1'b0;
        handshake_en = 1'b0;
        xfer_mode = 2'b00;
        req_count = 6'h03;
        tx_wr_en = 1'b0;
        tx_wr_addr = 6'h00;
        tx_wr_data = 8'h00;
        rx_rd_addr = 6'h00;
        mute = 1'b1; // busy held high: the status slot must not wait on it
        lag = 8'h05;
        hsm_slave_model_inst.ob[0] = 8'($urandom);
        hsm_slave_model_inst.ob[1] = 8'h48;
        repeat (6) @(posedge clock);
        check({4'h0, s1_n, s2_n, sck, sdo}, 8'h0f);
        resetn <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            d = 8'($urandom);
            exp_tx.push_back(d);
            tx_wr_en <= 1'b1;
            tx_wr_addr <= 6'(i);
            tx_wr_data <= d;
            @(posedge clock);
        end
        tx_wr_en <= 1'b0;
        run_slot();
        check(hsm_slave_model_inst.got[0], CMD_STAT);
        check(status_reply, 8'h48);
        check({6'h00, dslot, act}, 8'h02);
        for (int i = 1; i < 4; i++) begin
            d = 8'($urandom);
            hsm_slave_model_inst.ob[i] = d;
            exp_rx.push_back(d);
        end
        lag <= 8'h28;
        handshake_en <= 1'b1;
        mute <= 1'b0;
        run_slot();
        check(hsm_slave_model_inst.got[0], CMD_DUPLEX);
        check(8'(hsm_slave_model_inst.ng), 8'h04);
        for (int i = 0; i < 3; i++) begin
            check(hsm_slave_model_inst.got[i + 1], exp_tx[i]);
            rx_rd_addr <= 6'(i);
            repeat (2) @(posedge clock);
            check(rx_rd_data, exp_rx[i]);
        end
        check({6'h00, dslot, act}, 8'h01);
        mute <= 1'b1;
        @(posedge clock iff ste);
        @(posedge clock iff tte);
        repeat (3) @(posedge clock);
        check({5'h00, s1_n, s2_n, act}, 8'h06);
        check(8'(n_done), 8'h06);
        check(8'(n_short), 8'h00);
        check(8'(n_tick), 8'h03);
        finish_test();
    end
endmodule
bind hsm_master hsm_checker hsm_checker_inst (.clock, .resetn, .handshake_en, .busy_in,
    .serial_clock_out, .serial_data_out, .slave_select_one_n, .slave_select_two_n,
    .transfer_done_event, .slot_tick_event, .timeout_tick_event, .data_slot, .active_slave);
`default_nettype wire
